// *** core/psr_host.sv ***
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
module psr_host import psr_pkg::*; #(
	parameter int BOOT_CYCLES = BOOT_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	output logic             sclk,
	input  wire logic        miso,
	input  wire logic        rdy_ss_i,
	output logic             rdy_ss_o,
	output logic             rdy_ss_oe_n
);
	localparam int BW = $clog2(BOOT_CYCLES + 1);

	psr_mst_e      st;
	psr_cmd_s      cmd;
	psr_cmd_s      next_cmd;
	logic [BW-1:0] boot_cnt;
	logic          go;
	logic          acc;
	logic          accept;
	logic          ctrl_wr;
	logic          nb_ok;
	logic          wr_pend;
	logic [7:0]    wr_adr;
	logic          rd_pend;
	logic [7:0]    rd_adr;
	logic [31:0]   cfg;
	logic [31:0]   gap;
	logic [31:0]   gap_cnt;
	logic [31:0]   next_rdata;
	logic [31:0]   stat_w;
	logic [15:0]   brg;
	logic [10:0]   tmp;
	logic          stale;
	logic          nak;
	logic          ref_err;
	logic          rdy_seen;
	logic [2:0]    rdy_s;
	logic          rdy_f;
	logic          rdy_q;
	logic          i_done;
	logic          i_nak;
	logic [31:0]   i_data;
	logic          p_done;
	logic [31:0]   p_data;
	logic          done_any;
	logic [31:0]   d;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Bus side: writes take no wait, reads one wait so they see fresh writes
	always_comb begin
		acc = hsel && hready && htrans[1] && hsize == 3'h2;
		ctrl_wr = wr_pend && wr_adr == OFS_CTRL;
		nb_ok = hwdata[2:0] == 3'h0 ||
			(hwdata[2:0] >= 3'h2 && hwdata[2:0] <= 3'h4);
		accept = ctrl_wr && st == M_IDLE && nb_ok &&
			gap_cnt >= gap;
		next_cmd.spi = cfg[CFG_SPI];
		next_cmd.rise = cfg[CFG_RISE];
		next_cmd.addr = cfg[CFG_ADR +: 7];
		next_cmd.nb = hwdata[2:0];
		done_any = i_done || p_done;
		d = cmd.spi ? p_data : i_data;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_adr <= 8'h0;
			rd_pend <= 1'b0;
			rd_adr <= 8'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			wr_pend <= acc && hwrite;
			rd_pend <= acc && !hwrite;
			if (acc) begin
				wr_adr <= haddr[7:0];
				rd_adr <= haddr[7:0];
			end
			hreadyout <= !(acc && !hwrite);
			hresp <= 1'b0;
			if (rd_pend)
				hrdata <= next_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= CFG_RST;
			gap <= GAP_RST;
		end else if (wr_pend && wr_adr == OFS_CFG) begin
			cfg <= hwdata;
		end else if (wr_pend && wr_adr == OFS_GAP) begin
			gap <= hwdata;
		end
	end

	always_comb begin
		stat_w = 32'h0;
		stat_w[ST_BUSY] = st == M_BUSY;
		stat_w[ST_UP] = st != M_BOOT;
		stat_w[ST_RDY] = rdy_seen;
		stat_w[ST_NAK] = nak;
		stat_w[ST_STALE] = stale;
		stat_w[ST_REF] = ref_err;
		case (rd_adr)
		OFS_CTRL: next_rdata = {29'h0, cmd.nb};
		OFS_CFG:  next_rdata = cfg;
		OFS_GAP:  next_rdata = gap;
		OFS_STAT: next_rdata = stat_w;
		OFS_BRG:  next_rdata = {16'h0, brg};
		OFS_TMP:  next_rdata = {21'h0, tmp};
		default:  next_rdata = 32'h0;
		endcase
	end

	// Sequencer: no command leaves until the sensor's start-up has passed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= M_BOOT;
			boot_cnt <= '0;
			go <= 1'b0;
			cmd <= '0;
		end else begin
			go <= accept;
			unique case (st)
			M_BOOT: begin
				boot_cnt <= boot_cnt + BW'(1);
				if (boot_cnt == BW'(BOOT_CYCLES - 1))
					st <= M_IDLE;
			end
			M_IDLE: if (accept) begin
				cmd <= next_cmd;
				st <= M_BUSY;
			end
			M_BUSY: if (done_any)
				st <= M_IDLE;
			endcase
		end
	end

	// Spacing counts from command start, saturating so it never wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gap_cnt <= 32'hffffffff;
		else if (accept)
			gap_cnt <= 32'h0;
		else if (gap_cnt != 32'hffffffff)
			gap_cnt <= gap_cnt + 32'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brg <= 16'h0;
			tmp <= 11'h0;
			stale <= 1'b0;
			nak <= 1'b0;
		end else if (done_any) begin
			nak <= !cmd.spi && i_nak;
			if (cmd.nb >= 3'h2) begin
				brg <= d[31:16];
				stale <= d[31:30] == STALE_CODE;
				if (cmd.nb == 3'h4)
					tmp <= {d[15:8], d[7:5]};
				else if (cmd.nb == 3'h3)
					tmp <= {d[15:8], 3'h0};
				else
					tmp <= 11'h0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ref_err <= 1'b0;
		else if (ctrl_wr && !accept)
			ref_err <= 1'b1;
		else if (accept)
			ref_err <= 1'b0;
	end

	// Ready pin is asynchronous to hclk; first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_s <= 3'h0;
			rdy_f <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			rdy_s <= {rdy_s[1:0], rdy_ss_i};
			if (rdy_s[1] == rdy_s[2])
				rdy_f <= rdy_s[2];
			rdy_q <= rdy_f;
		end
	end

	// A rise in the clearing cycle keeps the flag set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_seen <= 1'b0;
		end else begin
			if (accept && next_cmd.nb != 3'h0)
				rdy_seen <= 1'b0;
			if (rdy_f && !rdy_q && !cfg[CFG_SPI])
				rdy_seen <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			rdy_ss_oe_n <= 1'b1;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			rdy_ss_oe_n <= !cfg[CFG_SPI];
		end
	end

	psr_i2c_rd u_i2c (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.go       (go),
		.cmd      (cmd),
		.sda_i    (sda_i),
		.scl_oe_n (scl_oe_n),
		.sda_oe_n (sda_oe_n),
		.done     (i_done),
		.nak      (i_nak),
		.data     (i_data)
	);

	psr_spi_rd u_spi (
		.hclk    (hclk),
		.hresetn (hresetn),
		.go      (go),
		.cmd     (cmd),
		.miso    (miso),
		.sclk    (sclk),
		.ss_n    (rdy_ss_o),
		.done    (p_done),
		.data    (p_data)
	);

	AST_BOOT: assert property (st == M_BOOT |-> !go && !accept)
		else $error("command sent during start-up");
	AST_BOOT_END: assert property ($fell(st == M_BOOT) |->
		$past(boot_cnt) == BW'(BOOT_CYCLES - 1))
		else $error("start-up wait ended early");
	AST_GAP: assert property (go |-> $past(gap_cnt) >= $past(gap))
		else $error("poll spacing violated");
	AST_BRG: assert property (done_any && cmd.nb >= 3'h2 |=>
		brg == $past(d[31:16]))
		else $error("bridge result not stored");
	AST_MASK: assert property (done_any && cmd.nb == 3'h4 |=>
		tmp[2:0] == $past(d[7:5]) && tmp[10:3] == $past(d[15:8]))
		else $error("temperature not assembled");
	AST_T8: assert property (done_any && cmd.nb == 3'h3 |=>
		tmp[2:0] == 3'h0)
		else $error("short fetch left low temperature bits");
	AST_REFUSE: assert property (ctrl_wr && st != M_IDLE |=> ref_err && !go)
		else $error("command taken while not idle");
	AST_RDWAIT: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	COV_REQ: cover property (go && cmd.nb == 3'h0);
	COV_SPI4: cover property (done_any && cmd.spi && cmd.nb == 3'h4);
	COV_I2C2: cover property (done_any && !cmd.spi && cmd.nb == 3'h2);
	COV_REF: cover property (ctrl_wr && !accept);
endmodule // psr_host

// *** core/psr_i2c_rd.sv ***
`timescale 1ns/100ps
module psr_i2c_rd import psr_pkg::*; (
	input  wire logic      hclk,
	input  wire logic      hresetn,
	input  wire logic      go,
	input  wire psr_cmd_s  cmd,
	input  wire logic      sda_i,
	output logic           scl_oe_n,
	output logic           sda_oe_n,
	output logic           done,
	output logic           nak,
	output logic [31:0]    data
);
	psr_i2c_e    st;
	psr_cmd_s    c;
	logic [2:0]  s;
	logic        sda_f;
	logic [8:0]  qcnt;
	logic        tick;
	logic [1:0]  q;
	logic [3:0]  pos;
	logic [2:0]  byt;
	logic [31:0] sh;
	logic        bit_lo;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	always_comb tick = qcnt == 9'(I2CQ_CYC - 1);
	always_comb begin
		if (byt == 3'h0)
			bit_lo = (pos < 4'h7) && !c.addr[3'(4'h6 - pos)];
		else
			bit_lo = (pos == 4'h8) && (byt != c.nb);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s     <= 3'h7;
			sda_f <= 1'b1;
		end else begin
			s <= {s[1:0], sda_i};
			if (s[1] == s[2])
				sda_f <= s[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			qcnt <= 9'h0;
		else
			qcnt <= (st == I_IDLE || tick) ? 9'h0 : qcnt + 9'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= I_IDLE;
			c <= '0;
			q <= 2'h0;
			pos <= 4'h0;
			byt <= 3'h0;
			sh <= 32'h0;
			nak <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			done <= 1'b0;
			data <= 32'h0;
		end else begin
			done <= 1'b0;
			unique case (st)
			I_IDLE: if (go && !cmd.spi) begin
				c <= cmd;
				q <= 2'h0;
				pos <= 4'h0;
				byt <= 3'h0;
				sh <= 32'h0;
				nak <= 1'b0;
				st <= I_START;
			end
			I_START: if (tick) begin
				q <= q + 2'h1;
				if (q == 2'h0) begin
					sda_oe_n <= 1'b0;
				end else begin
					scl_oe_n <= 1'b0;
					q <= 2'h0;
					st <= I_BIT;
				end
			end
			I_BIT: if (tick) begin
				q <= q + 2'h1;
				unique case (q)
				2'h0: sda_oe_n <= !bit_lo;
				2'h1: scl_oe_n <= 1'b1;
				2'h2: begin
					if (byt == 3'h0 && pos == 4'h8)
						nak <= sda_f;
					else if (byt != 3'h0 && pos != 4'h8)
						sh <= {sh[30:0], sda_f};
				end
				2'h3: begin
					scl_oe_n <= 1'b0;
					pos <= pos + 4'h1;
					if (pos == 4'h8) begin
						pos <= 4'h0;
						byt <= byt + 3'h1;
						if (byt == c.nb || nak)
							st <= I_STOP;
					end
				end
				endcase
			end
			I_STOP: if (tick) begin
				q <= q + 2'h1;
				unique case (q)
				2'h0: sda_oe_n <= 1'b0;
				2'h1: scl_oe_n <= 1'b1;
				2'h2: sda_oe_n <= 1'b1;
				2'h3: begin
					done <= 1'b1;
					data <= sh << {3'h4 - c.nb, 3'h0};
					st <= I_IDLE;
				end
				endcase
			end
			default: st <= I_IDLE;
			endcase
		end
	end

	AST_STOP: assert property ($rose(sda_oe_n) && st == I_STOP |-> scl_oe_n)
		else $error("stop not made with SCL high");
	AST_NACK: assert property (st == I_BIT && pos == 4'h8 && byt != 3'h0 &&
		q == 2'h2 |-> sda_oe_n == (byt == c.nb))
		else $error("wrong ack or nack from host");
endmodule // psr_i2c_rd

// *** core/psr_pkg.sv ***
package psr_pkg;
// What this block does
// - No command to the sensor within 10 ms of power-up.
// - Host polls no faster than refresh period plus 20 percent.
// - Measurement request is address with read bit; acked, host then stops.
// - Host may trigger measurement with two or three byte fetch, discarding data.
// - Fetch returns bytes until host NACK and stop; bridge first, status on top.
// - Four-byte fetch completes 11-bit temperature; host masks low 5 bits.
// - Host ends I2C fetch after two bytes when temperature is unneeded.
// - SPI measurement request: select low for at least 8 us, then high.
// - Sensor changes MISO after falling SCLK; host samples on rising SCLK. With CFG_RISE set the host samples on falling SCLK.
// - Host may end SPI read after second or third byte.

	localparam int HCLK_NS    = 5;
	localparam int BOOT_NS    = 10_000_000;
	localparam int BOOT_CYC   = (BOOT_NS + HCLK_NS - 1) / HCLK_NS;
	localparam int SSREQ_NS   = 8_000;
	localparam int SSREQ_CYC  = (SSREQ_NS + HCLK_NS - 1) / HCLK_NS;
	localparam int SSLEAD_NS  = 2_500;
	localparam int SSLEAD_CYC = (SSLEAD_NS + HCLK_NS - 1) / HCLK_NS;
	localparam int SPIH_NS    = 1_000;
	localparam int SPIH_CYC   = (SPIH_NS + HCLK_NS - 1) / HCLK_NS;
	localparam int I2CQ_NS    = 625;
	localparam int I2CQ_CYC   = (I2CQ_NS + HCLK_NS - 1) / HCLK_NS;
	localparam int POLL_NS    = 600_000;
	localparam int POLL_CYC   = (POLL_NS + HCLK_NS - 1) / HCLK_NS;

	localparam logic [7:0]  OFS_CTRL = 8'h00;
	localparam logic [7:0]  OFS_CFG  = 8'h04;
	localparam logic [7:0]  OFS_GAP  = 8'h08;
	localparam logic [7:0]  OFS_STAT = 8'h0c;
	localparam logic [7:0]  OFS_BRG  = 8'h10;
	localparam logic [7:0]  OFS_TMP  = 8'h14;
	localparam int          CFG_SPI  = 0;
	localparam int          CFG_RISE = 1;
	localparam int          CFG_ADR  = 8;
	localparam logic [31:0] CFG_RST  = 32'h00002800;
	localparam logic [31:0] GAP_RST  = 32'(POLL_CYC);
	localparam int          ST_BUSY  = 0;
	localparam int          ST_UP    = 1;
	localparam int          ST_RDY   = 2;
	localparam int          ST_NAK   = 3;
	localparam int          ST_STALE = 4;
	localparam int          ST_REF   = 5;
	localparam logic [1:0]  STALE_CODE = 2'h2;

	typedef struct packed {
		logic       spi;
		logic       rise;
		logic [6:0] addr;
		logic [2:0] nb;
	} psr_cmd_s;

	typedef enum logic [2:0] {
		M_BOOT = 3'h1, M_IDLE = 3'h2, M_BUSY = 3'h4
	} psr_mst_e;
	typedef enum logic [3:0] {
		I_IDLE = 4'h1, I_START = 4'h2, I_BIT = 4'h4, I_STOP = 4'h8
	} psr_i2c_e;
	typedef enum logic [3:0] {
		P_IDLE = 4'h1, P_LEAD = 4'h2, P_CLK = 4'h4, P_HOLD = 4'h8
	} psr_spi_e;
endpackage

// *** core/psr_spi_rd.sv ***
`timescale 1ns/100ps
module psr_spi_rd import psr_pkg::*; (
	input  wire logic      hclk,
	input  wire logic      hresetn,
	input  wire logic      go,
	input  wire psr_cmd_s  cmd,
	input  wire logic      miso,
	output logic           sclk,
	output logic           ss_n,
	output logic           done,
	output logic [31:0]    data
);
	psr_spi_e    st;
	psr_cmd_s    c;
	logic [2:0]  s;
	logic        miso_f;
	logic [10:0] cnt;
	logic [10:0] lim;
	logic        end_hs;
	logic [5:0]  bits;
	logic [31:0] sh;
	logic [13:0] low_cnt;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	always_comb begin
		if (st == P_HOLD && c.nb == 3'h0)
			lim = 11'(SSREQ_CYC - 1);
		else if (st == P_LEAD)
			lim = 11'(SSLEAD_CYC - 1);
		else
			lim = 11'(SPIH_CYC - 1);
		end_hs = cnt == lim;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s      <= 3'h0;
			miso_f <= 1'b0;
		end else begin
			s <= {s[1:0], miso};
			if (s[1] == s[2])
				miso_f <= s[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= P_IDLE;
			c <= '0;
			cnt <= 11'h0;
			bits <= 6'h0;
			sh <= 32'h0;
			sclk <= 1'b0;
			ss_n <= 1'b1;
			done <= 1'b0;
			data <= 32'h0;
		end else begin
			done <= 1'b0;
			cnt <= (st == P_IDLE || end_hs) ? 11'h0 : cnt + 11'h1;
			unique case (st)
			P_IDLE: if (go && cmd.spi) begin
				c <= cmd;
				bits <= 6'h0;
				sh <= 32'h0;
				ss_n <= 1'b0;
				st <= (cmd.nb == 3'h0) ? P_HOLD : P_LEAD;
			end
			P_LEAD: if (end_hs)
				st <= P_CLK;
			P_CLK: if (end_hs) begin
				sclk <= !sclk;
				if (sclk == c.rise)
					sh <= {sh[30:0], miso_f};
				if (sclk) begin
					bits <= bits + 6'h1;
					if (bits == {c.nb, 3'h0} - 6'h1)
						st <= P_HOLD;
				end
			end
			P_HOLD: if (end_hs) begin
				ss_n <= 1'b1;
				done <= 1'b1;
				data <= sh << {3'h4 - c.nb, 3'h0};
				st <= P_IDLE;
			end
			default: st <= P_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_cnt <= 14'h0;
		else if (ss_n)
			low_cnt <= 14'h0;
		else if (low_cnt != 14'h3fff)
			low_cnt <= low_cnt + 14'h1;
	end

	AST_SS_REQ: assert property ($rose(ss_n) && c.nb == 3'h0 |->
		low_cnt >= 14'(SSREQ_CYC))
		else $error("select low too short for a request");
	AST_SAMPLE: assert property (st == P_CLK && $changed(sh) |->
		(c.rise ? $fell(sclk) : $rose(sclk)))
		else $error("MISO taken on the wrong edge");
endmodule // psr_spi_rd

// *** testbench/psr_sensor_model.sv ***
`timescale 1ns/100ps
module psr_sensor_model import psr_pkg::*; #(
	parameter logic [6:0] ADDR    = 7'h28,
	parameter int         MEAS_NS = 20000
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_n,
	input  wire logic sclk,
	input  wire logic ss_n,
	output logic      miso,
	output logic      rdy,
	input  wire logic spi_mode,
	input  wire logic rise_mode
);
	logic [1:0]  st  = STALE_CODE;
	logic [13:0] brg = 14'h0;
	logic [10:0] tmp = 11'h0;
	logic [31:0] sh;
	logic [7:0]  a;
	logic        aok = 1'b0;
	logic        fv  = 1'b0;
	int          nby = 0;
	int          k   = -1;
	int          cnt = 0;
	realtime     t0;
	event        meas;
	wire  [31:0] pkt = {st, brg, tmp, 5'h15};
	initial begin
		sda_n = 1'b1;
		miso = 1'b0;
		rdy = 1'b0;
	end
	// Sleep mode only; no refresh timing
	always @(meas) begin
		st = STALE_CODE;
		rdy = 1'b0;
		#(MEAS_NS);
		cnt++;
		brg = 14'(cnt * 'h123);
		tmp = 11'(cnt * 'h15);
		st = 2'h0;
		rdy = 1'b1;
	end
	always begin
		@(negedge sda iff scl === 1'b1);
		begin : xfer
			nby = 0;
			repeat (8) @(posedge scl) a = {a[6:0], sda};
			@(negedge scl);
			if (a !== {ADDR, 1'b1})
				disable xfer;
			sda_n = 1'b0;
			aok = 1'b1;
			sh = pkt;
			fv = st != STALE_CODE;
			forever begin
				repeat (8) begin
					@(negedge scl);
					sda_n = sh[31];
					sh = sh << 1;
				end
				@(negedge scl);
				sda_n = 1'b1;
				@(posedge scl);
				nby++;
				if (sda)
					disable xfer;
			end
		end
	end
	always @(posedge sda) if (scl === 1'b1) begin
		disable xfer;
		sda_n = 1'b1;
		if (aok && nby == 0)
			->meas;
		else if (nby > 0 && fv) begin
			st = STALE_CODE;
			rdy = 1'b0;
		end
		aok = 1'b0;
	end
	always @(negedge ss_n) if (spi_mode) begin
		t0 = $realtime;
		k = 0;
		sh = pkt;
		fv = st != STALE_CODE;
		if (!rise_mode)
			miso = sh[31];
	end
	always @(sclk) if (spi_mode && k >= 0 && sclk === rise_mode) begin
		if (!rise_mode)
			sh = sh << 1;
		miso = sh[31];
		if (rise_mode)
			sh = sh << 1;
		k++;
	end
	always @(posedge ss_n) if (spi_mode && k >= 0) begin
		if (k == 0 && $realtime - t0 >= 8000)
			->meas;
		else if (k > 0 && fv) begin
			st = STALE_CODE;
			rdy = 1'b0;
		end
		miso = ~miso; // Released line shows no stale level
		k = -1;
	end
endmodule // psr_sensor_model

// *** testbench/tb_psr_host.sv ***
`timescale 1ns/100ps
module tb_psr_host import psr_pkg::*;;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hwrite  = 1'b0;
	logic        spi_m   = 1'b0;
	logic        rise_m  = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] rd;
	logic [1:0]  htrans  = 2'h0;
	wire         hready, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n;
	wire         sclk, miso, sda_n, rdy, rdy_ss_o, rdy_ss_oe_n;
	wire  [31:0] hrdata;
	wire         sda    = sda_oe_n & sda_n; // Pull-up on the wire
	wire         scl    = scl_oe_n;
	wire         rdy_ss = rdy_ss_oe_n ? rdy : rdy_ss_o;
	int          failures = 0;
	int          n_tests  = 0;
	int          cyc      = 0;
	always #2.5 hclk = ~hclk;
	psr_host #(.BOOT_CYCLES(40)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .sclk(sclk), .miso(miso), .rdy_ss_i(rdy_ss),
		.rdy_ss_o(rdy_ss_o), .rdy_ss_oe_n(rdy_ss_oe_n));
	psr_sensor_model #(.ADDR(7'h28)) dev (.scl(scl), .sda(sda),
		.sda_n(sda_n), .sclk(sclk), .ss_n(rdy_ss), .miso(miso),
		.rdy(rdy), .spi_mode(spi_m), .rise_mode(rise_m));
	function automatic logic [13:0] brg_of(input int n);
		return 14'(n * 'h123);
	endfunction
	function automatic logic [10:0] tmp_of(input int n);
		return 11'(n * 'h15);
	endfunction
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 90000) begin // Hang guard
			failures++;
			conclude;
		end
	end
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic poll(input int b, input logic v);
		int i;
		i = 0;
		do begin
			ahb(1'b0, OFS_STAT, 32'h0);
			i++;
		end while (rd[b] !== v && i < 40000);
		chk("status poll", 32'(v), 32'(rd[b]));
	endtask
	task automatic cmd(input logic [2:0] nb);
		ahb(1'b1, OFS_CTRL, {29'h0, nb});
		repeat (3) @(posedge hclk);
		poll(ST_BUSY, 1'b0);
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("cfg", OFS_CFG, CFG_RST);
		rdchk("gap", OFS_GAP, GAP_RST);
		ahb(1'b1, OFS_CTRL, 32'h2);
		ahb(1'b0, OFS_STAT, 32'h0);
		chk("early", 32'h2, {30'h0, rd[ST_REF], rd[ST_UP]});
		poll(ST_UP, 1'b1);
		ahb(1'b1, OFS_GAP, 32'h190);
		cmd(3'h0);
		chk("nak", 32'h0, 32'(rd[ST_NAK]));
		poll(ST_RDY, 1'b1);
		cmd(3'h2);
		rdchk("brg i2c", OFS_BRG, {18'h0, brg_of(1)});
		rdchk("tmp two", OFS_TMP, 32'h0);
		ahb(1'b1, OFS_CFG, 32'h2803);
		spi_m <= 1'b1;
		rise_m <= 1'b1;
		cmd(3'h2);
		rdchk("brg rise", OFS_BRG, {16'h0, STALE_CODE, brg_of(1)});
		ahb(1'b1, OFS_CFG, 32'h2801);
		rise_m <= 1'b0;
		cmd(3'h0);
		cmd(3'h3);
		rdchk("brg busy", OFS_BRG, {16'h0, STALE_CODE, brg_of(1)});
		rdchk("tmp three", OFS_TMP, {21'h0, tmp_of(1) & 11'h7f8});
		cmd(3'h4);
		rdchk("brg spi", OFS_BRG, {18'h0, brg_of(2)});
		rdchk("tmp spi", OFS_TMP, {21'h0, tmp_of(2)});
		ahb(1'b1, OFS_CTRL, 32'h5);
		ahb(1'b0, OFS_STAT, 32'h0);
		chk("bad count", 32'h1, 32'(rd[ST_REF]));
		chk("resp", 32'h0, 32'(hresp));
		rdchk("ctrl", OFS_CTRL, 32'h4);
		conclude;
	end
endmodule // tb_psr_host
